// ### common/cmp_pkg.sv
package cmp_pkg;

   // register byte offsets on the plain register port
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFS_CONFIG = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_CTRL0 = 8'h08;
   localparam logic [7:0] OFS_CTRL1 = 8'h0C;
   localparam logic [7:0] OFS_FLAGS = 8'h10;
   localparam logic [7:0] OFS_FLAG_SET = 8'h14;
   localparam logic [7:0] OFS_GATE = 8'h18;
   localparam logic [7:0] OFS_GATED = 8'h1C;

   // field positions
   localparam int GLOBAL_EN_BIT = 31;
   localparam int PWR_LSB = 0;
   localparam int PWR_MSB = 1;
   localparam int HYST_BIT = 5;
   localparam int EDGE_LSB = 6;
   localparam int EDGE_MSB = 7;
   localparam int LVL0_BIT = 0;
   localparam int LVL1_BIT = 16;
   localparam int NUM_CMP = 2;

   // reset values and writable-bit masks
   localparam logic [31:0] CONFIG_RST = 32'h0000_0000;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] CONFIG_WMASK = 32'h8000_0000;
   localparam logic [31:0] CTRL_WMASK = 32'h0000_00E3;
   localparam logic [1:0] FLAGS_RST = 2'h0;
   localparam logic [1:0] GATE_RST = 2'h0;
   localparam logic [31:0] READ_IDLE = 32'h0000_0000;

   // interrupt edge selection
   typedef enum logic [1:0] {
      EDGE_NONE = 2'b00,
      EDGE_RISE = 2'b01,
      EDGE_FALL = 2'b10,
      EDGE_BOTH = 2'b11
   } edge_sel_t;

   // comparator power selection
   typedef enum logic [1:0] {
      PWR_OFF = 2'b00,
      PWR_ULP = 2'b01,
      PWR_LP = 2'b10,
      PWR_NORMAL = 2'b11
   } power_sel_t;

endpackage : cmp_pkg

// ### common/edge_if.sv
`timescale 1ns/100ps
// links the control core to one edge detector
interface edge_if;
   import cmp_pkg::*;
   logic lvl; // raw comparator output
   edge_sel_t sel; // edge selection
   logic en; // detection enabled
   logic evt; // one-cycle edge event
   modport det (input lvl, input sel, input en, output evt);
   modport ctl (output lvl, output sel, output en, input evt);
endinterface : edge_if

// ### rtl/cmp_edge_detect.sv
`timescale 1ns/100ps
module cmp_edge_detect
   import cmp_pkg::*;
(
   input wire logic clk_sys, // system clock
   input wire logic nrst, // sync reset, active low
   input wire logic ce, // clock enable
   edge_if.det port // level in, event out
);

   logic s1_r, s2_r, prev_r, evt_r;
   logic s1_nxt, s2_nxt, prev_nxt, evt_nxt;
   logic rise, fall, hit;

   // two-stage synchroniser, then compare with previous sample
   always_comb
   begin
      s1_nxt = port.lvl;
      s2_nxt = s1_r;
      prev_nxt = s2_r;
      rise = s2_r & ~prev_r;
      fall = ~s2_r & prev_r;
      unique case (port.sel)
         EDGE_NONE: hit = 1'b0;
         EDGE_RISE: hit = rise;
         EDGE_FALL: hit = fall;
         EDGE_BOTH: hit = rise | fall;
      endcase
      evt_nxt = port.en & hit;
   end

   // state registers on the system clock only
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         prev_r <= 1'b0;
         evt_r <= 1'b0;
      end
      else if (ce)
      begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
         prev_r <= prev_nxt;
         evt_r <= evt_nxt;
      end
   end

   assign port.evt = evt_r;

endmodule : cmp_edge_detect

// ### rtl/dual_comparator_irq_ctrl.sv
`timescale 1ns/100ps
// Contract
// - status read returns live unregistered comparator levels at bits 0 and 16
// - edge field bits 7:6: none, rising, falling, or both edges raise interrupt
// - edge event sets the comparator flag; writing one clears it
// - writing one to the set register raises that comparator's flag
// - mode bits 1:0 select off, ultra-low, low, or normal power
// - global enable bit 31 must be set, with a non-off mode, to power each comparator
// - control bit 5 enables the fixed hysteresis
// - an enabled edge event raises the wakeup request once its gate bit is set
// - gate bits decide which flags reach the processor
// - read-only view shows flags anded with gate bits
// - all interrupt logic runs on the single system main clock
// - one shared interrupt output, the or of both gated flags
// - an uncleared flag keeps the interrupt asserted while its gate bit stays set
// - gate register holds one gate bit per comparator
module dual_comparator_irq_ctrl
   import cmp_pkg::*;
(
   input wire logic clk_sys, // system main clock, 10 MHz
   input wire logic nrst, // sync reset, active low
   input wire logic ce, // clock enable, freezes state when low
   input wire logic [ADDR_W-1:0] addr, // register byte address
   input wire logic [31:0] wdata, // write data
   input wire logic wr_en, // write strobe
   input wire logic rd_en, // read strobe
   output logic [31:0] rdata, // read data, cycle after strobe
   input wire logic first_cmp_level, // first comparator output, async
   input wire logic second_cmp_level, // second comparator output, async
   output logic first_cmp_enable, // first comparator powered
   output logic second_cmp_enable, // second comparator powered
   output logic [1:0] first_power_select, // first comparator power mode
   output logic [1:0] second_power_select, // second comparator power mode
   output logic first_hysteresis_enable, // first comparator hysteresis
   output logic second_hysteresis_enable, // second comparator hysteresis
   output logic irq, // shared interrupt, level
   output logic wakeup_req // wakeup request, level
);

   // register state
   logic [31:0] config_r, config_nxt;
   logic [31:0] ctrl0_r, ctrl0_nxt;
   logic [31:0] ctrl1_r, ctrl1_nxt;
   logic [1:0] flags_r, flags_nxt;
   logic [1:0] gate_r, gate_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic irq_r, irq_nxt;
   logic wake_r, wake_nxt;
   logic [1:0] en_r, en_nxt;

   // decoded strobes and helpers
   logic wr_config, wr_ctrl0, wr_ctrl1;
   logic wr_flags, wr_set, wr_gate;
   logic global_en;
   logic [1:0] hw_evt;
   logic [1:0] sw_set;
   logic [1:0] sw_clr;
   logic [1:0] gated;
   logic [31:0] status_word;

   // one edge detector per comparator
   edge_if eif[NUM_CMP] ();

   assign eif[0].lvl = first_cmp_level;
   assign eif[1].lvl = second_cmp_level;
   assign eif[0].sel = edge_sel_t'(ctrl0_r[EDGE_MSB:EDGE_LSB]);
   assign eif[1].sel = edge_sel_t'(ctrl1_r[EDGE_MSB:EDGE_LSB]);
   assign eif[0].en = en_r[0];
   assign eif[1].en = en_r[1];

   genvar gi;
   generate
      for (gi = 0; gi < NUM_CMP; gi++)
      begin : g_det
         cmp_edge_detect u_det (
            .clk_sys(clk_sys),
            .nrst(nrst),
            .ce(ce),
            .port(eif[gi])
         );
         assign hw_evt[gi] = eif[gi].evt;
      end
   endgenerate

   // address decode of write strobes
   always_comb
   begin
      wr_config = wr_en && (addr == OFS_CONFIG);
      wr_ctrl0 = wr_en && (addr == OFS_CTRL0);
      wr_ctrl1 = wr_en && (addr == OFS_CTRL1);
      wr_flags = wr_en && (addr == OFS_FLAGS);
      wr_set = wr_en && (addr == OFS_FLAG_SET);
      wr_gate = wr_en && (addr == OFS_GATE);
      sw_clr = wr_flags ? wdata[1:0] : 2'h0;
      sw_set = wr_set ? wdata[1:0] : 2'h0;
   end

   // configuration and control registers: only writable bits stick, the
   // rest of each word reads back as zero
   always_comb
   begin
      config_nxt = config_r;
      ctrl0_nxt = ctrl0_r;
      ctrl1_nxt = ctrl1_r;
      if (wr_config)
      begin
         config_nxt = wdata & CONFIG_WMASK;
      end
      if (wr_ctrl0)
      begin
         ctrl0_nxt = wdata & CTRL_WMASK;
      end
      if (wr_ctrl1)
      begin
         ctrl1_nxt = wdata & CTRL_WMASK;
      end
   end

   // configuration and control state, frozen while ce is low
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         config_r <= CONFIG_RST;
         ctrl0_r <= CTRL_RST;
         ctrl1_r <= CTRL_RST;
      end
      else if (ce)
      begin
         config_r <= config_nxt;
         ctrl0_r <= ctrl0_nxt;
         ctrl1_r <= ctrl1_nxt;
      end
   end

   // gate register, one bit per comparator; a cleared gate bit hides that
   // flag from the interrupt but leaves the flag itself untouched
   always_comb
   begin
      gate_nxt = gate_r;
      if (wr_gate)
      begin
         gate_nxt = wdata[1:0];
      end
   end

   // gate state
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         gate_r <= GATE_RST;
      end
      else if (ce)
      begin
         gate_r <= gate_nxt;
      end
   end

   // comparator enables: global bit and a non-off mode both needed; taken from
   // the next register values so an enable never outlives a write that turns
   // its comparator off
   always_comb
   begin
      global_en = config_nxt[GLOBAL_EN_BIT];
      en_nxt[0] = global_en && (ctrl0_nxt[PWR_MSB:PWR_LSB] != PWR_OFF);
      en_nxt[1] = global_en && (ctrl1_nxt[PWR_MSB:PWR_LSB] != PWR_OFF);
   end

   // enable state
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         en_r <= 2'h0;
      end
      else if (ce)
      begin
         en_r <= en_nxt;
      end
   end

   // sticky flags: any set wins over a simultaneous clear
   always_comb
   begin
      flags_nxt = (flags_r & ~sw_clr) | hw_evt | sw_set;
   end

   // flag state
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         flags_r <= FLAGS_RST;
      end
      else if (ce)
      begin
         flags_r <= flags_nxt;
      end
   end

   // gated flags drive the shared interrupt; built from the next flag and gate
   // values so the line always agrees with the gated view software reads
   always_comb
   begin
      gated = flags_r & gate_r;
      irq_nxt = |(flags_nxt & gate_nxt);
   end

   // interrupt state
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         irq_r <= 1'b0;
      end
      else if (ce)
      begin
         irq_r <= irq_nxt;
      end
   end

   // wakeup request follows the same gated flags, so a comparator wakes the
   // device only once software has opened its gate
   always_comb
   begin
      wake_nxt = |(flags_nxt & gate_nxt);
   end

   // wakeup state
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         wake_r <= 1'b0;
      end
      else if (ce)
      begin
         wake_r <= wake_nxt;
      end
   end

   // live levels, not synchronised, for the status word; a read may show a
   // level change that the edge detectors have not yet turned into a flag
   always_comb
   begin
      status_word = READ_IDLE;
      status_word[LVL0_BIT] = first_cmp_level;
      status_word[LVL1_BIT] = second_cmp_level;
   end

   // read mux; data valid only in the cycle after the strobe
   // the set register reads back the flags, as it holds no state of its own
   always_comb
   begin
      rdata_nxt = READ_IDLE;
      if (rd_en)
      begin
         unique case (addr)
            OFS_CONFIG: rdata_nxt = config_r;
            OFS_STATUS: rdata_nxt = status_word;
            OFS_CTRL0: rdata_nxt = ctrl0_r;
            OFS_CTRL1: rdata_nxt = ctrl1_r;
            OFS_FLAGS: rdata_nxt = {30'h0000_0000, flags_r};
            OFS_FLAG_SET: rdata_nxt = {30'h0000_0000, flags_r};
            OFS_GATE: rdata_nxt = {30'h0000_0000, gate_r};
            OFS_GATED: rdata_nxt = {30'h0000_0000, gated};
            default: rdata_nxt = READ_IDLE; // unmapped reads as zero
         endcase
      end
   end

   // read data register; it falls back to zero one cycle after the answer
   // so a stale word is never mistaken for a new answer
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         rdata_r <= READ_IDLE;
      end
      else if (ce)
      begin
         rdata_r <= rdata_nxt;
      end
   end

   // outputs straight from flip-flops
   assign rdata = rdata_r;
   assign irq = irq_r;
   assign wakeup_req = wake_r;
   assign first_cmp_enable = en_r[0];
   assign second_cmp_enable = en_r[1];
   assign first_power_select = ctrl0_r[PWR_MSB:PWR_LSB];
   assign second_power_select = ctrl1_r[PWR_MSB:PWR_LSB];
   assign first_hysteresis_enable = ctrl0_r[HYST_BIT];
   assign second_hysteresis_enable = ctrl1_r[HYST_BIT];

endmodule : dual_comparator_irq_ctrl

// ### sim/cmp_core_model.sv
`timescale 1ns/100ps
// two analog comparator cores seen from their digital outputs
module cmp_core_model (
   input wire logic en0, // first core powered
   input wire logic en1, // second core powered
   input wire logic ana0, // first analog decision
   input wire logic ana1, // second analog decision
   output logic lvl0, // first core output
   output logic lvl1 // second core output
);
   // an unpowered core is pulled low and shows no decision
   assign lvl0 = en0 & ana0;
   assign lvl1 = en1 & ana1;
endmodule : cmp_core_model

// ### sim/dual_comparator_irq_ctrl_asserts.sv
`timescale 1ns/100ps
module dual_comparator_irq_ctrl_asserts
   import cmp_pkg::*;
(
   input wire logic clk_sys, // clock
   input wire logic nrst, // reset
   input wire logic [ADDR_W-1:0] addr, // address
   input wire logic [31:0] wdata, // write data
   input wire logic wr_en, // write
   input wire logic rd_en, // read
   input wire logic [31:0] rdata, // read data
   input wire logic first_cmp_level, // level 0
   input wire logic second_cmp_level, // level 1
   input wire logic first_cmp_enable, // enable 0
   input wire logic second_cmp_enable, // enable 1
   input wire logic [1:0] first_power_select, // mode 0
   input wire logic [1:0] second_power_select, // mode 1
   input wire logic first_hysteresis_enable, // hyst 0
   input wire logic second_hysteresis_enable, // hyst 1
   input wire logic irq, // interrupt
   input wire logic wakeup_req // wakeup
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);
   // wakeup mirrors the shared interrupt
   AST_WAKE: assert property (wakeup_req == irq)
      else $error("wakeup differs from irq");
   // read data only in the answer cycle
   AST_RD_IDLE: assert property (!$past(rd_en) |-> rdata == 32'h0000_0000)
      else $error("read data outside answer cycle");
   // status returns the raw levels seen at the read edge
   AST_STATUS: assert property (rd_en && addr == OFS_STATUS |=>
      rdata == {15'h0, $past(second_cmp_level), 15'h0, $past(first_cmp_level)})
      else $error("status levels wrong");
   // gated view agrees with the shared interrupt
   AST_GATED: assert property (rd_en && addr == OFS_GATED |=>
      (|rdata) == $past(irq))
      else $error("gated view and irq disagree");
   // a powered comparator never has the off mode
   AST_EN_MODE: assert property ((first_cmp_enable -> first_power_select != 2'h0)
      && (second_cmp_enable -> second_power_select != 2'h0))
      else $error("enabled while off");
   // a control write reaches mode and hysteresis outputs
   AST_CTRL: assert property (wr_en && addr == OFS_CTRL0 |-> ##2
      first_power_select == $past(wdata[1:0], 2) && first_hysteresis_enable == $past(wdata[5], 2))
      else $error("control outputs wrong");
   // a second control write reaches its mode and hysteresis outputs
   AST_CTRL1: assert property (wr_en && addr == OFS_CTRL1 |-> ##2
      second_power_select == $past(wdata[1:0], 2)
      && second_hysteresis_enable == $past(wdata[5], 2))
      else $error("second control outputs wrong");
   // global disable powers both comparators down
   AST_GLOBAL: assert property (wr_en && addr == OFS_CONFIG && !wdata[31] |-> ##2
      !first_cmp_enable && !second_cmp_enable)
      else $error("enable survives global off");
   // an uncleared gated flag keeps the interrupt up
   AST_HOLD: assert property (irq && !(wr_en && (addr == OFS_FLAGS || addr == OFS_GATE))
      |=> irq)
      else $error("irq dropped without clear");
endmodule : dual_comparator_irq_ctrl_asserts
bind dual_comparator_irq_ctrl dual_comparator_irq_ctrl_asserts i_asserts (.clk_sys, .nrst,
   .addr, .wdata, .wr_en, .rd_en, .rdata, .first_cmp_level, .second_cmp_level,
   .first_cmp_enable, .second_cmp_enable, .first_power_select, .second_power_select,
   .first_hysteresis_enable, .second_hysteresis_enable, .irq, .wakeup_req);

// ### sim/dual_comparator_irq_ctrl_test.sv
`timescale 1ns/100ps
module dual_comparator_irq_ctrl_test;
   import cmp_pkg::*;
   logic clk_sys, nrst, ce, wr_en, rd_en, rd_d, irq, en0, en1, lvl0, lvl1;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, r;
   logic [32:0] got, e, exp_q[$];
   logic [1:0] ana;
   int miscompares, total_checks;
   dual_comparator_irq_ctrl i_dut (.clk_sys, .nrst, .ce, .addr, .wdata, .wr_en,
      .rd_en, .rdata, .first_cmp_level(lvl0), .second_cmp_level(lvl1),
      .first_cmp_enable(en0), .second_cmp_enable(en1), .first_power_select(),
      .second_power_select(), .first_hysteresis_enable(), .second_hysteresis_enable(),
      .irq, .wakeup_req());
   cmp_core_model i_cores (.en0, .en1, .ana0(ana[0]), .ana1(ana[1]), .lvl0, .lvl1);
   // clock
   initial
   begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      rd_en <= 1'b0;
      @(posedge clk_sys);
   endtask : wr
   // a read notes the expected irq level and answer
   task automatic rd(input logic [7:0] a, input logic [32:0] x);
      exp_q.push_back(x);
      addr <= a;
      wr_en <= 1'b0;
      rd_en <= 1'b1;
      @(posedge clk_sys);
   endtask : rd
   task automatic gap(input int n);
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      repeat (n) @(posedge clk_sys);
   endtask : gap
   task automatic end_of_test;
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_of_test
   // compares each answer and irq with the oldest note
   always @(posedge clk_sys)
   begin
      rd_d <= rd_en;
      if (rd_d === 1'b1)
      begin
         got = {irq, rdata};
         e = exp_q.pop_front();
         total_checks++;
         if (got !== e)
         begin
            miscompares++;
            $display("CHECK FAILED %0t exp %h got %h", $time, e, got);
         end
      end
   end
   // cuts a hung run short
   initial
   begin
      repeat (2000) @(posedge clk_sys);
      miscompares++;
      end_of_test();
   end
   initial
   begin
      nrst = 1'b0;
      ce = 1'b1;
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr = 8'h00;
      wdata = 32'h0000_0000;
      ana = 2'b00;
      r = $urandom(32'h0000_84cf);
      repeat (10) @(posedge clk_sys);
      nrst <= 1'b1;
      // reset values and an unmapped place read zero
      for (int a = 0; a <= 32; a += 4)
         rd(8'(a), 33'h0);
      // only writable bits stick; an unmapped write is ignored
      r = $urandom();
      wr(OFS_CONFIG, r);
      wr(OFS_CTRL0, r);
      wr(OFS_CTRL1, ~r);
      wr(8'h20, 32'hffff_ffff);
      rd(OFS_CONFIG, {1'b0, r & CONFIG_WMASK});
      rd(OFS_CTRL0, {1'b0, r & CTRL_WMASK});
      rd(OFS_CTRL1, {1'b0, ~r & CTRL_WMASK});
      wr(OFS_CTRL0, 32'h0);
      wr(OFS_CTRL1, 32'h0);
      wr(OFS_GATE, 32'h3);
      wr(OFS_CONFIG, 32'h8000_0000);
      // every edge selection on both comparators
      for (int c = 0; c < 2; c++)
         for (int s = 0; s < 4; s++)
         begin
            wr(OFS_CTRL0 + 8'(4 * c), {24'h0, 2'(s), 6'h01});
            ana[c] <= 1'b1;
            gap(6);
            rd(OFS_STATUS, {s[0], 32'h1 << (16 * c)});
            rd(OFS_FLAGS, {s[0], 32'(s[0]) << c});
            wr(OFS_FLAGS, 32'h3);
            ana[c] <= 1'b0;
            gap(6);
            rd(OFS_FLAGS, {s[1], 32'(s[1]) << c});
            wr(OFS_FLAGS, 32'h3);
         end
      // both levels up while enabled, then global off: the power-down edges
      // are lost; a gate write with ce low is lost too
      ana <= 2'b11;
      gap(6);
      rd(OFS_STATUS, {1'b1, 32'h0001_0001});
      wr(OFS_FLAGS, 32'h3);
      wr(OFS_CONFIG, 32'h0);
      gap(6);
      ce <= 1'b0;
      wr(OFS_GATE, 32'h0);
      ce <= 1'b1;
      rd(OFS_FLAGS, 33'h0);
      wr(OFS_FLAG_SET, 32'h1);
      rd(OFS_FLAGS, {1'b1, 32'h1});
      wr(OFS_GATE, 32'h2);
      rd(OFS_GATED, 33'h0);
      wr(OFS_FLAG_SET, 32'h2);
      rd(OFS_GATED, {1'b1, 32'h2});
      wr(OFS_FLAGS, 32'h2);
      rd(OFS_FLAGS, {1'b0, 32'h1});
      gap(2);
      end_of_test();
   end
endmodule : dual_comparator_irq_ctrl_test
